/* File: pkg/brw_pkg.sv */
// package: bus states, request carriers and constants for the ready and wait-state block
package brw_pkg;
  // ************************************************************
  // bus state machine
  // ************************************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01, // idle_state
    ST_FIRST  = 6'h02,
    ST_SECOND = 6'h04, // second_bus_state
    ST_THIRD  = 6'h08, // third_bus_state
    ST_WAIT   = 6'h10, // wait_state
    ST_FINAL  = 6'h20  // final_bus_state
  } brw_state_t;

  // ************************************************************
  // widths, depths, reset values
  // ************************************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int QUEUE_DEPTH = 6;  // prefetch queue bytes
  localparam int QPTR_W = 3;
  localparam logic SYNC_RESET_VAL = 1'b0;
  localparam logic [ADDR_W-1:0] FETCH_ADDR_RESET = 20'hFFFF0;
  localparam logic [QPTR_W:0] QUEUE_FULL_BYTES = 4'h6;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic ignore_ready; // internal register or chip select says ignore ready
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic byte_only;
  } brw_req_t;

  typedef struct packed {
    logic cycle_active;
    logic is_fetch;
    logic is_write;
    logic ignore_ready;
    logic [ADDR_W-1:0] addr;
    logic word;
  } brw_cycle_t;

  // fetch address step: full word from even address, single byte from odd
  function automatic logic [ADDR_W-1:0] brw_next_fetch(input logic [ADDR_W-1:0] a);
    brw_next_fetch = a[0] ? a + 20'h00001 : a + 20'h00002;
  endfunction
endpackage

/* File: rtl/brw_queue_mem.sv */
// prefetch queue storage: small byte memory with registered read data
`timescale 1ns/100ps
module brw_queue_mem
  import brw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [QPTR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [QPTR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_reg [QUEUE_DEPTH];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // registered read; a byte written on the same edge is passed through so a fresh head is not stale
  always_comb
  begin
    rd_data_next = (wr_en && wr_addr == rd_addr) ? wr_data : mem_reg[rd_addr];
  end

  // memory is not reset; contents are only read behind the valid count
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_reg <= 8'h00;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

/* File: rtl/brw_bus_ready.sv */
// bus cycle sequencer with ready sampling, wait states and prefetch queue
// Behaviour
// - wait only when sync ready and latch-gated async ready are both low; either ends the cycle
// - wait states repeat without limit while neither ready is active
// - ignore ready for internal registers and ready-ignoring chip-select regions
// - async ready passes a resolution flop then a second latch flop
// - latch stage high passes live async level; low forces not-ready
// - async ready early and held gives zero wait states
// - async ready low at either stage generates wait states
// - sync ready sampled only at the edge ending third and wait states
// - sync ready active at sample goes straight to final state next
// - sync ready inactive at sample inserts a wait state next
// - sync ready changes away from sampling points cause no harm
// - bus idles while queue full and no read or write requested
// - prefetch runs independently of execution consuming the queue
// - fetches are even-address words, except after a jump to odd
`timescale 1ns/100ps
module brw_bus_ready
  import brw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sync_ready_in,
  input wire logic async_ready_in,
  input wire brw_req_t exec_req,
  output logic exec_ack,
  output logic [DATA_W-1:0] exec_rdata,
  input wire logic jump_valid,
  input wire logic [ADDR_W-1:0] jump_addr,
  input wire logic queue_pop,
  output logic queue_valid,
  output logic [7:0] queue_byte,
  output brw_cycle_t cycle_out,
  output brw_state_t bus_state,
  input wire logic [DATA_W-1:0] bus_rdata,
  output logic [DATA_W-1:0] bus_wdata
);
  // ************************************************************
  // async ready synchroniser
  // ************************************************************
  logic resolve_reg, resolve_next;
  logic latch_reg, latch_next;
  logic async_ok;

  // first flop only feeds the second flop
  always_comb
  begin
    resolve_next = async_ready_in;
    latch_next = resolve_reg;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resolve_reg <= SYNC_RESET_VAL;
      latch_reg <= SYNC_RESET_VAL;
    end
    else
    begin
      resolve_reg <= resolve_next;
      latch_reg <= latch_next;
    end
  end

  // latched stage gates the live pin: a low at either stage means wait
  assign async_ok = latch_reg & async_ready_in;

  // ************************************************************
  // bus state machine
  // ************************************************************
  brw_state_t state_reg, state_next;
  brw_cycle_t cyc_reg, cyc_next;
  logic [ADDR_W-1:0] fetch_reg, fetch_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic ack_reg, ack_next;
  logic flush_reg, flush_next;
  logic [QPTR_W:0] count_reg, count_next;
  logic [QPTR_W-1:0] wptr_reg, wptr_next;
  logic [QPTR_W-1:0] rptr_reg, rptr_next;
  logic ready_now;
  logic room_word;
  logic push_lo, push_hi;
  logic [QPTR_W-1:0] wptr_inc;

  // ready decision only looked at in third and wait states
  assign ready_now = cyc_reg.ignore_ready | sync_ready_in | async_ok;
  assign room_word = (count_reg + 4'h2) <= QUEUE_FULL_BYTES;

  function automatic logic [QPTR_W-1:0] ptr_inc(input logic [QPTR_W-1:0] p);
    ptr_inc = (p == 3'(QUEUE_DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    fetch_next = fetch_reg;
    rdata_next = rdata_reg;
    wdata_next = wdata_reg;
    ack_next = 1'b0;
    flush_next = flush_reg | jump_valid;
    case (state_reg)
      ST_IDLE, ST_FINAL:
      begin
        cyc_next.cycle_active = 1'b0;
        // a pending flush ends here; the jump target is already loaded
        if (jump_valid || flush_reg)
        begin
          flush_next = 1'b0;
        end
        // execution requests win over prefetch
        if (exec_req.valid && !ack_reg)
        begin
          cyc_next = '{1'b1, 1'b0, exec_req.write, exec_req.ignore_ready,
                       exec_req.addr, !exec_req.byte_only};
          wdata_next = exec_req.wdata;
          state_next = ST_FIRST;
        end
        else if (!jump_valid && !flush_reg && room_word)
        begin
          // prefetch in parallel with execution
          cyc_next = '{1'b1, 1'b1, 1'b0, 1'b0, fetch_reg, !fetch_reg[0]};
          state_next = ST_FIRST;
        end
        else
        begin
          state_next = ST_IDLE;
        end
      end
      ST_FIRST:
      begin
        state_next = ST_SECOND;
      end
      ST_SECOND:
      begin
        state_next = ST_THIRD;
      end
      ST_THIRD, ST_WAIT:
      begin
        // inputs looked at only here, so other edges are harmless
        if (ready_now)
        begin
          state_next = ST_FINAL;
          rdata_next = bus_rdata;
          if (!cyc_reg.is_fetch)
          begin
            ack_next = 1'b1;
          end
          else if (!flush_reg)
          begin
            fetch_next = brw_next_fetch(fetch_reg);
          end
        end
        else
        begin
          state_next = ST_WAIT;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    // a jump retargets fetching in any state, so a mid-cycle jump is not lost
    if (jump_valid)
    begin
      fetch_next = jump_addr;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      cyc_reg <= '0;
      fetch_reg <= FETCH_ADDR_RESET;
      rdata_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      flush_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      fetch_reg <= fetch_next;
      rdata_reg <= rdata_next;
      wdata_reg <= wdata_next;
      ack_reg <= ack_next;
      flush_reg <= flush_next;
    end
  end

  // ************************************************************
  // prefetch queue
  // ************************************************************
  // fetch data land at the end of the ready state; a flushed fetch is dropped
  logic fetch_done;
  assign fetch_done = (state_reg == ST_THIRD || state_reg == ST_WAIT) && ready_now
                      && cyc_reg.is_fetch && !jump_valid && !flush_reg;
  assign push_lo = fetch_done;
  assign push_hi = fetch_done && cyc_reg.word;
  assign wptr_inc = ptr_inc(wptr_reg);

  logic pop_ok;
  logic [7:0] push_byte;
  logic push_any;
  logic [QPTR_W-1:0] push_addr;
  logic hi_pending_reg, hi_pending_next;
  logic [7:0] hi_byte_reg, hi_byte_next;

  // the odd byte of a word is written one cycle later through the single port
  always_comb
  begin
    hi_pending_next = push_hi;
    hi_byte_next = bus_rdata[15:8];
    pop_ok = queue_pop && (count_reg != 4'h0);
    push_any = push_lo || hi_pending_reg;
    push_addr = wptr_reg;
    push_byte = hi_pending_reg ? hi_byte_reg :
                (cyc_reg.addr[0] ? bus_rdata[15:8] : bus_rdata[7:0]);
    wptr_next = push_any ? ptr_inc(wptr_reg) : wptr_reg;
    rptr_next = pop_ok ? ptr_inc(rptr_reg) : rptr_reg;
    count_next = count_reg + {3'h0, push_lo} + {3'h0, push_hi} - {3'h0, pop_ok};
    if (jump_valid)
    begin
      // jump flushes the queue
      wptr_next = 3'h0;
      rptr_next = 3'h0;
      count_next = 4'h0;
      hi_pending_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= 4'h0;
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      hi_pending_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
    end
    else
    begin
      count_reg <= count_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      hi_pending_reg <= hi_pending_next;
      hi_byte_reg <= hi_byte_next;
    end
  end

  brw_queue_mem u_queue
  (
    .clk(clk),
    .nrst(nrst),
    .wr_en(push_any && !jump_valid),
    .wr_addr(push_addr),
    .wr_data(push_byte),
    .rd_addr(rptr_next),
    .rd_data(queue_byte)
  );

  // head byte is valid as soon as it is stored; a word's low byte does not wait for its high byte
  assign queue_valid = (count_reg != 4'h0) && !(count_reg == 4'h1 && hi_pending_reg)
                       && !(hi_pending_reg && count_reg == 4'h2 && wptr_inc == rptr_reg);
  assign exec_ack = ack_reg;
  assign exec_rdata = rdata_reg;
  assign cycle_out = cyc_reg;
  assign bus_state = state_reg;
  assign bus_wdata = wdata_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  a_wait_needs_low: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_THIRD || state_reg == ST_WAIT) && state_next == ST_WAIT
    |-> !sync_ready_in && !async_ok && !cyc_reg.ignore_ready)
    else $error("wait state inserted while ready active");
  a_sync_ends: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_THIRD || state_reg == ST_WAIT) && sync_ready_in
    |=> state_reg == ST_FINAL)
    else $error("sync ready did not end cycle");
  a_not_ready_waits: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_THIRD || state_reg == ST_WAIT) && !ready_now
    |=> state_reg == ST_WAIT)
    else $error("not ready did not wait");
  a_ignore_ready: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_THIRD && cyc_reg.ignore_ready |=> state_reg == ST_FINAL)
    else $error("ready not ignored");
  a_sync_chain: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> latch_reg == $past(resolve_reg) && resolve_reg == $past(async_ready_in))
    else $error("synchroniser chain broken");
  a_async_gate: assert property (@(posedge clk) disable iff (!nrst)
    !latch_reg |-> !async_ok)
    else $error("async ready passed while latched low");
  a_cycle_order: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_FIRST |=> state_reg == ST_SECOND ##1 state_reg == ST_THIRD)
    else $error("bus state order wrong");
  a_zero_wait: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_FIRST && async_ready_in ##1 async_ready_in ##1 async_ready_in
    |-> state_next == ST_FINAL)
    else $error("wait inserted despite early async ready");
  a_idle_full: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_IDLE && !room_word && !exec_req.valid && !flush_reg
    |=> state_reg == ST_IDLE)
    else $error("bus left idle with full queue");
  a_even_fetch: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_FIRST && cyc_reg.is_fetch && !cyc_reg.addr[0] |-> cyc_reg.word)
    else $error("even fetch not a word");
  a_reset_sync: assert property (@(posedge clk)
    $rose(nrst) |-> !latch_reg)
    else $error("synchroniser not cleared");

  c_zero_wait: cover property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_THIRD ##1 state_reg == ST_FINAL);
  c_many_waits: cover property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_WAIT [*3] ##1 state_reg == ST_FINAL);
  c_exec_cycle: cover property (@(posedge clk) disable iff (!nrst) exec_ack);
  c_odd_fetch: cover property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_FIRST && cyc_reg.is_fetch && cyc_reg.addr[0]);
endmodule

/* File: test/brw_mem_model.sv */
// partner model: slow memory that drives both ready lines and read data
`timescale 1ns/100ps
module brw_mem_model
  import brw_pkg::*;
(
  input wire logic clk,
  input wire brw_state_t bus_state,
  input wire brw_cycle_t cycle_out,
  input wire logic [1:0] mode,
  input wire logic [7:0] wait_n,
  output logic sync_ready_in,
  output logic async_ready_in,
  output logic [DATA_W-1:0] bus_rdata
);
  logic [7:0] ph;
  logic win;
  logic busy;
  logic [7:0] lo;
  logic [1:0] md;
  logic [7:0] wn;
  // ************************************************************
  // ready and data, changed just after each edge
  // ************************************************************
  initial
  begin
    ph = 8'h00;
    md = 2'h0;
    wn = 8'h00;
    sync_ready_in = 1'b0;
    async_ready_in = 1'b0;
    bus_rdata = 16'h0000;
  end
  // mode 0 sync only, 1 async only, 2 one-cycle async pulse then sync
  always @(posedge clk)
  begin
    #1;
    ph = (bus_state == ST_FIRST) ? 8'h00 : ph + 8'h01;
    // settings held per cycle so a change mid-fetch cannot strand it
    if (bus_state == ST_FIRST)
    begin
      md = mode;
      wn = wait_n;
    end
    win = bus_state inside {ST_THIRD, ST_WAIT};
    busy = win || bus_state inside {ST_FIRST, ST_SECOND};
    // toggles away from sampling points; must do no harm
    sync_ready_in = win ? (md != 2'h1 && ph >= wn + 8'h02) : ~sync_ready_in;
    // normally not ready: held across three edges to end the cycle
    async_ready_in = busy && (md == 2'h1 ? (ph >= wn && ph <= wn + 8'h02) :
      (md == 2'h2 && ph == 8'h02));
    lo = cycle_out.addr[7:0] & 8'hFE;
    // outside a cycle the data lines change every cycle
    bus_rdata = busy ? {(lo | 8'h01) ^ 8'h3C, lo ^ 8'h3C} : ~bus_rdata;
  end
endmodule

/* File: test/tb.sv */
// self-checking bench for the ready and wait-state sequencer
`timescale 1ns/100ps
module tb;
  import brw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  brw_req_t exec_req = '0;
  logic jump_valid = 1'b0;
  logic [ADDR_W-1:0] jump_addr = '0;
  logic queue_pop = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] wait_n = 8'h00;
  logic sync_ready_in, async_ready_in, exec_ack, queue_valid;
  logic [DATA_W-1:0] exec_rdata, bus_rdata, bus_wdata;
  logic [7:0] queue_byte;
  brw_cycle_t cycle_out;
  brw_state_t bus_state;
  int num_errors = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  int waits, pre;
  logic [ADDR_W:0] fq[$];
  brw_bus_ready brw_bus_ready_i (.clk(clk), .nrst(nrst), .sync_ready_in(sync_ready_in),
    .async_ready_in(async_ready_in), .exec_req(exec_req), .exec_ack(exec_ack),
    .exec_rdata(exec_rdata), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .queue_pop(queue_pop), .queue_valid(queue_valid), .queue_byte(queue_byte),
    .cycle_out(cycle_out), .bus_state(bus_state), .bus_rdata(bus_rdata), .bus_wdata(bus_wdata));
  brw_mem_model brw_mem_model_i (.clk(clk), .bus_state(bus_state), .cycle_out(cycle_out),
    .mode(mode), .wait_n(wait_n), .sync_ready_in(sync_ready_in),
    .async_ready_in(async_ready_in), .bus_rdata(bus_rdata));
  // ************************************************************
  // clock, watchdog, bus monitor
  // ************************************************************
  initial
  begin
    forever #20 clk = ~clk;
  end
  // a hung handshake ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 6000)
    begin
      num_errors++;
      summarize();
    end
  end
  // sampled mid-cycle, away from the edges the design updates on
  always @(negedge clk)
  begin
    if (cycle_out.cycle_active && !cycle_out.is_fetch && !(bus_state inside {ST_IDLE, ST_FINAL}))
      pre++;
    if (cycle_out.cycle_active && !cycle_out.is_fetch && bus_state == ST_WAIT)
      waits++;
    if (cycle_out.is_fetch && bus_state == ST_SECOND)
      fq.push_back({cycle_out.word, cycle_out.addr});
  end
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] byte_of(logic [19:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_v(string nm, logic [19:0] e, logic [19:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_n(string nm, int e, int g);
    total_checks++;
    if (g != e)
    begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one execution cycle; ready-ignoring cycles must never wait
  task automatic run_exec(logic [19:0] a, logic wr, logic ign, logic [1:0] md, logic [7:0] n);
    int k;
    int ew;
    ew = ign ? 0 : int'(n);
    mode = md;
    wait_n = n;
    exec_req = '{valid: 1'b1, write: wr, ignore_ready: ign, addr: a, wdata: a[15:0],
      byte_only: 1'b0};
    waits = 0;
    pre = 0;
    for (k = 0; k < 300 && exec_ack !== 1'b1; k++)
      tick(1);
    chk_v("final state", 20'(ST_FINAL), 20'(bus_state));
    chk_n("wait states", ew, waits);
    chk_n("cycle length", 3 + ew, pre);
    if (!wr)
      chk_v("read data", {byte_of(a | 20'h1), byte_of(a)}, 20'(exec_rdata));
    if (wr)
      chk_v("write data", 20'(a[15:0]), 20'(bus_wdata));
    chk_v("write flag", 20'(wr), 20'(cycle_out.is_write));
    tick(1);
    exec_req.valid = 1'b0;
    tick(1);
    $display("test exec %0h done", a);
  endtask
  task automatic jump_to(logic [19:0] a);
    jump_valid = 1'b1;
    jump_addr = a;
    tick(1);
    jump_valid = 1'b0;
    fq.delete();
  endtask
  task automatic pop_check(logic [19:0] a, int cnt);
    int k;
    for (int i = 0; i < cnt; i++)
    begin
      for (k = 0; k < 60 && queue_valid !== 1'b1; k++)
        tick(1);
      chk_v("queue byte", 20'(byte_of(a + 20'(i))), 20'(queue_byte));
      queue_pop = 1'b1;
      tick(1);
      queue_pop = 1'b0;
      tick(2);
    end
    $display("test pop %0h done", a);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(72));
    tick(3);
    chk_v("reset state", 20'(ST_IDLE), 20'(bus_state));
    chk_v("reset queue", 20'h0, 20'(queue_valid));
    nrst = 1'b1;
    tick(1);
    run_exec(20'h00100, 1'b0, 1'b0, 2'h1, 8'h00);
    run_exec(20'h00200, 1'b0, 1'b0, 2'h1, 8'h03);
    run_exec(20'h00300, 1'b1, 1'b0, 2'h2, 8'h02);
    run_exec(20'h00400, 1'b0, 1'b1, 2'h0, 8'h05);
    run_exec(20'h00500, 1'b0, 1'b0, 2'h0, 8'h0C);
    repeat (16)
      run_exec(20'($urandom) & 20'hFFFFE, 1'($urandom), 1'b0, 2'($urandom_range(2)),
        8'($urandom_range(6)));
    mode = 2'h0;
    wait_n = 8'h00;
    jump_to(20'h01230);
    tick(60);
    chk_v("bus idle", 20'(ST_IDLE), 20'(bus_state));
    pop_check(20'h01230, 8);
    tick(60);
    jump_to(20'h04567);
    tick(40);
    chk_v("odd fetch", 20'h04567, fq[0][19:0]);
    chk_v("odd fetch word", 20'h0, 20'(fq[0][20]));
    chk_v("next fetch", 20'h04568, fq[1][19:0]);
    chk_v("next fetch word", 20'h1, 20'(fq[1][20]));
    pop_check(20'h04567, 8);
    $display("test queue done");
    summarize();
  end
endmodule
